/* hdl/asxc_top.sv */
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module asxc_top
  import asxc_pkg::*;
(
  input wire logic aclk, // System clock, 10 MHz
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [asxc_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [asxc_pkg::ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic carrier_detect_pin0_n, // Carrier detect, active low
  input wire logic clear_to_send_pin0_n, // Clear to send, active low
  input wire logic io_stop_mode, // I/O stop mode level
  input wire logic tx_data_empty_raw0, // Transmitter empty from core
  input wire logic [1:0] tx_serial, // Transmitter serial data per channel
  input wire logic [1:0] async_rx_pin, // Receive pins
  input wire logic [1:0] async_clock_pin_i, // Clock pin levels
  input wire logic [1:0] rx_head_new, // Pulse: new oldest Rx FIFO entry
  input wire logic [15:0] rx_head_data, // Oldest character, ch1 high byte
  input wire logic [1:0] rx_head_framing_err, // Framing error of that entry
  input wire logic [1:0] error_flag_reset_clr, // Pulse: zero written to ERROR_FLAG_RESET
  output logic [1:0] async_tx_pin, // Transmit pins
  output logic [1:0] async_clock_pin_o, // Clock pin drive level
  output logic [1:0] async_clock_pin_oe, // Clock pin drive enable
  output logic [1:0] bit_clk_en, // Pulse: one bit time
  output logic [1:0] rx_sync_data, // Receive data as sampled
  output logic rx_reset0, // Hold channel 0 receiver reset
  output logic tx_data_empty_flag0, // Gated transmit-empty flag
  output logic irq // Level interrupt
);
  import asxc_pkg::*;

  logic [7:0] ext_r [2];
  logic [7:0] ctlb_r [2];
  logic [15:0] tc_r [2];
  logic [1:0] brk_det_r;
  logic [IRQ_W-1:0] istat_r;
  logic [IRQ_W-1:0] imask_r;
  logic dcd_prev_r;
  logic [1:0] brk_set;
  logic [1:0] gen_pulse;
  logic dcd_gate;

  // Write channel
  logic aw_full_r, w_full_r;
  logic [ADDR_W-1:0] waddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_do, aw_full_nxt, w_full_nxt, bvalid_nxt;
  logic wr_ok;
  assign wr_do = aw_full_r & w_full_r & ~s_axi_bvalid;
  assign aw_full_nxt = (aw_full_r | (s_axi_awvalid & s_axi_awready)) & ~wr_do;
  assign w_full_nxt = (w_full_r | (s_axi_wvalid & s_axi_wready)) & ~wr_do;
  assign bvalid_nxt = s_axi_bvalid ? ~s_axi_bready : wr_do;
  always_comb begin
    case (waddr_r)
      OFS_EXT0, OFS_EXT1, OFS_CTLB0, OFS_CTLB1, OFS_TC0, OFS_TC1,
      OFS_LINE, OFS_ISTAT, OFS_IMASK: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ASXC_OKAY;
      waddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else begin
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      s_axi_awready <= ~aw_full_nxt & ~bvalid_nxt;
      s_axi_wready <= ~w_full_nxt & ~bvalid_nxt;
      s_axi_bvalid <= bvalid_nxt;
      if (s_axi_awvalid && s_axi_awready) begin
        waddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_do) begin
        s_axi_bresp <= wr_ok ? ASXC_OKAY : ASXC_SLVERR;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_r[0] <= EXT_RESET;
      ext_r[1] <= EXT_RESET;
      ctlb_r[0] <= CTLB_RESET;
      ctlb_r[1] <= CTLB_RESET;
      tc_r[0] <= TC_RESET;
      tc_r[1] <= TC_RESET;
      imask_r <= '0;
    end else if (wr_do) begin
      if (wstrb_r[0]) begin
        case (waddr_r)
          OFS_EXT0: ext_r[0] <= wdata_r[7:0] & EXT0_WMASK;
          OFS_EXT1: ext_r[1] <= wdata_r[7:0] & EXT1_WMASK;
          OFS_CTLB0: ctlb_r[0] <= wdata_r[7:0] & CTLB_WMASK;
          OFS_CTLB1: ctlb_r[1] <= wdata_r[7:0] & CTLB_WMASK;
          OFS_TC0: tc_r[0][7:0] <= wdata_r[7:0];
          OFS_TC1: tc_r[1][7:0] <= wdata_r[7:0];
          OFS_IMASK: imask_r <= wdata_r[IRQ_W-1:0];
          default: ;
        endcase
      end
      if (wstrb_r[1]) begin
        case (waddr_r)
          OFS_TC0: tc_r[0][15:8] <= wdata_r[15:8];
          OFS_TC1: tc_r[1][15:8] <= wdata_r[15:8];
          default: ;
        endcase
      end
    end
  end

  // Read channel
  logic [31:0] rd_mux;
  logic rd_ok;
  logic rvalid_nxt;
  assign rvalid_nxt = s_axi_rvalid ? ~s_axi_rready : (s_axi_arvalid & s_axi_arready);
  always_comb begin
    rd_mux = 32'h00000000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      OFS_EXT0: rd_mux[7:0] = ext_r[0] | {6'h00, brk_det_r[0], 1'b0};
      OFS_EXT1: rd_mux[7:0] = ext_r[1] | {6'h00, brk_det_r[1], 1'b0};
      OFS_CTLB0: rd_mux[7:0] = ctlb_r[0];
      OFS_CTLB1: rd_mux[7:0] = ctlb_r[1];
      OFS_TC0: rd_mux[15:0] = tc_r[0];
      OFS_TC1: rd_mux[15:0] = tc_r[1];
      OFS_LINE: rd_mux[2:0] = {tx_data_empty_flag0, clear_to_send_pin0_n,
                               carrier_detect_pin0_n};
      OFS_ISTAT: rd_mux[IRQ_W-1:0] = istat_r;
      OFS_IMASK: rd_mux[IRQ_W-1:0] = imask_r;
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= ASXC_OKAY;
    end else begin
      s_axi_arready <= ~rvalid_nxt & ~(s_axi_arvalid & s_axi_arready);
      s_axi_rvalid <= rvalid_nxt;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rdata <= rd_ok ? rd_mux : 32'h00000000;
        s_axi_rresp <= rd_ok ? ASXC_OKAY : ASXC_SLVERR;
      end
    end
  end

  // Channel 0 modem line gating
  assign dcd_gate = ~ext_r[0][EXT_DCD_DIS] & carrier_detect_pin0_n;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_reset0 <= 1'b0;
      tx_data_empty_flag0 <= 1'b0;
      dcd_prev_r <= 1'b1;
    end else begin
      rx_reset0 <= dcd_gate;
      tx_data_empty_flag0 <= tx_data_empty_raw0 &
        ~(~ext_r[0][EXT_CTS_DIS] & clear_to_send_pin0_n);
      dcd_prev_r <= carrier_detect_pin0_n;
    end
  end

  // Break detect; a new break wins over a software clear
  assign brk_set = {2{1'b1}} & {ext_r[1][EXT_BRK_EN], ext_r[0][EXT_BRK_EN]} & rx_head_new &
                   rx_head_framing_err &
                   {rx_head_data[15:8] == 8'h00, rx_head_data[7:0] == 8'h00};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      brk_det_r <= 2'b00;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (io_stop_mode || (c == 0 && dcd_gate)) begin
          brk_det_r[c] <= 1'b0;
        end else if (brk_set[c]) begin
          brk_det_r[c] <= 1'b1;
        end else if (error_flag_reset_clr[c]) begin
          brk_det_r[c] <= 1'b0;
        end
      end
    end
  end

  // Interrupt status, write one to clear, set wins
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] w1c;
  assign ev = {brk_set[1], brk_set[0], carrier_detect_pin0_n & ~dcd_prev_r};
  assign w1c = (wr_do && waddr_r == OFS_ISTAT && wstrb_r[0]) ? wdata_r[IRQ_W-1:0] : '0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      istat_r <= '0;
      irq <= 1'b0;
    end else begin
      istat_r <= (istat_r & ~w1c) | ev;
      irq <= |(((istat_r & ~w1c) | ev) & imask_r);
    end
  end

  // Baud generator, bit clock divider and pin muxing per channel
  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    logic [GEN_W-1:0] gen_cnt_r;
    logic [GEN_W-1:0] period_m1;
    logic [5:0] div_cnt_r;
    logic clk_prev_r;
    logic [2:0] ss;
    assign ss = ctlb_r[ch][CTLB_SS_LSB+2:CTLB_SS_LSB];
    always_comb begin
      if (ext_r[ch][EXT_BRG_MODE]) begin
        period_m1 = {1'b0, tc_r[ch], 1'b0} + TC_ADD_M1;
      end else begin
        period_m1 = ((ctlb_r[ch][CTLB_PS] ? PRESCALE_HI : PRESCALE_LO) << ss) -
                    18'h00001;
      end
    end
    assign gen_pulse[ch] = (ss == SS_BYPASS) ? (async_clock_pin_i[ch] & ~clk_prev_r) :
                           (gen_cnt_r == '0);
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        gen_cnt_r <= '0;
        div_cnt_r <= '0;
        clk_prev_r <= 1'b0;
        bit_clk_en[ch] <= 1'b0;
        async_clock_pin_o[ch] <= 1'b0;
        async_clock_pin_oe[ch] <= 1'b0;
        rx_sync_data[ch] <= 1'b1;
        async_tx_pin[ch] <= 1'b1;
      end else begin
        clk_prev_r <= async_clock_pin_i[ch];
        gen_cnt_r <= (gen_cnt_r == '0 || gen_cnt_r > period_m1) ? period_m1 :
                     gen_cnt_r - 18'h00001;
        async_clock_pin_oe[ch] <= (ss != SS_BYPASS);
        async_clock_pin_o[ch] <= (ss != SS_BYPASS) & gen_pulse[ch];
        if (ext_r[ch][EXT_X1]) begin
          bit_clk_en[ch] <= gen_pulse[ch];
          div_cnt_r <= '0;
          if (gen_pulse[ch]) begin
            rx_sync_data[ch] <= async_rx_pin[ch];
          end
        end else begin
          rx_sync_data[ch] <= async_rx_pin[ch];
          if (gen_pulse[ch]) begin
            if (div_cnt_r >= (ctlb_r[ch][CTLB_DR] ? DIV_HI_M1 : DIV_LO_M1)) begin
              div_cnt_r <= '0;
              bit_clk_en[ch] <= 1'b1;
            end else begin
              div_cnt_r <= div_cnt_r + 6'h01;
              bit_clk_en[ch] <= 1'b0;
            end
          end else begin
            bit_clk_en[ch] <= 1'b0;
          end
        end
        async_tx_pin[ch] <= (ext_r[ch][EXT_SEND_BRK] & ext_r[ch][EXT_BRK_EN]) ? 1'b0 :
                            tx_serial[ch];
      end
    end
  end

  property p_dcd_hold;
    @(posedge aclk) disable iff (!aresetn)
    (!ext_r[0][EXT_DCD_DIS] && carrier_detect_pin0_n) |=> rx_reset0;
  endproperty
  a_dcd_hold: assert property (p_dcd_hold) else $error("receiver not held");
  property p_dcd_off;
    @(posedge aclk) disable iff (!aresetn)
    ext_r[0][EXT_DCD_DIS] |=> !rx_reset0;
  endproperty
  a_dcd_off: assert property (p_dcd_off) else $error("carrier gating active");
  property p_dcd_irq;
    @(posedge aclk) disable iff (!aresetn)
    $rose(carrier_detect_pin0_n) |=> istat_r[IRQ_DCD_RISE];
  endproperty
  a_dcd_irq: assert property (p_dcd_irq) else $error("carrier edge lost");
  property p_cts;
    @(posedge aclk) disable iff (!aresetn)
    (!ext_r[0][EXT_CTS_DIS] && clear_to_send_pin0_n) |=> !tx_data_empty_flag0;
  endproperty
  a_cts: assert property (p_cts) else $error("empty flag not forced");
  property p_x1;
    @(posedge aclk) disable iff (!aresetn)
    (ext_r[0][EXT_X1] && gen_pulse[0]) |=> bit_clk_en[0];
  endproperty
  a_x1: assert property (p_x1) else $error("single rate clock missing");
  property p_div;
    @(posedge aclk) disable iff (!aresetn)
    (!ext_r[0][EXT_X1] && bit_clk_en[0]) |=> (!bit_clk_en[0] || ext_r[0][EXT_X1]) [*8];
  endproperty
  a_div: assert property (p_div) else $error("bit clock too fast");
  property p_brg0;
    @(posedge aclk) disable iff (!aresetn)
    (g_ch[0].ss != SS_BYPASS && $stable(ctlb_r[0]) && !ext_r[0][EXT_BRG_MODE] &&
     gen_pulse[0]) |=>
    (!gen_pulse[0] || ext_r[0][EXT_BRG_MODE] || g_ch[0].ss == SS_BYPASS) [*8];
  endproperty
  a_brg0: assert property (p_brg0) else $error("prescaler too short");
  property p_brg1;
    @(posedge aclk) disable iff (!aresetn)
    (ext_r[0][EXT_BRG_MODE] && tc_r[0] == 16'h0000 && g_ch[0].ss != SS_BYPASS &&
     $stable(tc_r[0]) && gen_pulse[0]) |=> !gen_pulse[0] ##1 !gen_pulse[0] ##1
     !gen_pulse[0];
  endproperty
  a_brg1: assert property (p_brg1) else $error("time constant period short");
  property p_brk_set;
    @(posedge aclk) disable iff (!aresetn)
    (brk_set[0] && !io_stop_mode && !dcd_gate) |=> brk_det_r[0];
  endproperty
  a_brk_set: assert property (p_brk_set) else $error("break not caught");
  property p_brk_clr;
    @(posedge aclk) disable iff (!aresetn)
    io_stop_mode |=> !brk_det_r[0] && !brk_det_r[1];
  endproperty
  a_brk_clr: assert property (p_brk_clr) else $error("break not cleared");
  property p_send_brk;
    @(posedge aclk) disable iff (!aresetn)
    (ext_r[1][EXT_SEND_BRK] && ext_r[1][EXT_BRK_EN]) |=> !async_tx_pin[1];
  endproperty
  a_send_brk: assert property (p_send_brk) else $error("break not sent");
  property p_no_brk;
    @(posedge aclk) disable iff (!aresetn)
    !ext_r[0][EXT_BRK_EN] |=> async_tx_pin[0] == $past(tx_serial[0]);
  endproperty
  a_no_brk: assert property (p_no_brk) else $error("break while disabled");
  property p_rst;
    @(posedge aclk) !aresetn |=> ext_r[0] == EXT_RESET && ext_r[1] == EXT_RESET;
  endproperty
  a_rst: assert property (p_rst) else $error("extension not reset");
  property p_bypass;
    @(posedge aclk) disable iff (!aresetn)
    g_ch[0].ss == SS_BYPASS |=> !async_clock_pin_oe[0];
  endproperty
  a_bypass: assert property (p_bypass) else $error("clock pin driven");
endmodule : asxc_top

/* include/asxc_pkg.sv */
package asxc_pkg;
  localparam int ADDR_W = 6;
  localparam logic [ADDR_W-1:0] OFS_EXT0 = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_EXT1 = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_CTLB0 = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_CTLB1 = 6'h0c;
  localparam logic [ADDR_W-1:0] OFS_TC0 = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_TC1 = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_LINE = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_ISTAT = 6'h1c;
  localparam logic [ADDR_W-1:0] OFS_IMASK = 6'h20;
  // Extension control fields
  localparam int EXT_DCD_DIS = 6;
  localparam int EXT_CTS_DIS = 5;
  localparam int EXT_X1 = 4;
  localparam int EXT_BRG_MODE = 3;
  localparam int EXT_BRK_EN = 2;
  localparam int EXT_BRK_DET = 1;
  localparam int EXT_SEND_BRK = 0;
  localparam logic [7:0] EXT_RESET = 8'h00;
  localparam logic [7:0] EXT0_WMASK = 8'h7d;
  localparam logic [7:0] EXT1_WMASK = 8'h1d;
  // Control register B fields
  localparam int CTLB_SS_LSB = 0;
  localparam int CTLB_DR = 3;
  localparam int CTLB_PS = 5;
  localparam logic [7:0] CTLB_WMASK = 8'h2f;
  localparam logic [7:0] CTLB_RESET = 8'h00;
  localparam logic [15:0] TC_RESET = 16'h0000;
  localparam logic [2:0] SS_BYPASS = 3'h7;
  // Interrupt status bits
  localparam int IRQ_DCD_RISE = 0;
  localparam int IRQ_BRK0 = 1;
  localparam int IRQ_BRK1 = 2;
  localparam int IRQ_W = 3;
  // Divider figures
  localparam int GEN_W = 18;
  localparam logic [GEN_W-1:0] PRESCALE_LO = 18'h0000a;
  localparam logic [GEN_W-1:0] PRESCALE_HI = 18'h0001e;
  localparam logic [GEN_W-1:0] TC_ADD_M1 = 18'h00003;
  localparam logic [5:0] DIV_LO_M1 = 6'h0f;
  localparam logic [5:0] DIV_HI_M1 = 6'h3f;
  typedef enum logic [1:0] {
    ASXC_OKAY = 2'b00,
    ASXC_SLVERR = 2'b10
  } asxc_resp_t;
endpackage : asxc_pkg

/* testbench/asxc_line_model.sv */
`timescale 1ns/1ps
module asxc_line_model (
  input wire logic aclk, // System clock
  input wire logic carrier_on, // Remote end raises carrier
  input wire logic cts_on, // Remote end ready to accept data
  input wire logic ext_on, // Remote end drives the clock pins
  input wire logic [1:0] rx_bits, // Next data levels to send
  input wire logic [1:0] gen_tick, // Clock pin pulses from the device
  output logic carrier_detect_pin0_n, // Carrier detect, active low
  output logic clear_to_send_pin0_n, // Clear to send, active low
  output logic [1:0] async_rx_pin, // Serial data towards the device
  output logic [1:0] async_clock_pin_i // Clock pin levels
);
  logic [2:0] div_r;
  initial begin
    div_r = 3'h0;
    async_rx_pin = 2'b11;
  end
  assign carrier_detect_pin0_n = !carrier_on;
  assign clear_to_send_pin0_n = !cts_on;
  // External clock stands still unless enabled
  always @(posedge aclk) begin
    div_r <= ext_on ? div_r + 3'h1 : 3'h0;
  end
  assign async_clock_pin_i = {2{div_r[2]}};
  // Data only moves on a clock pin edge
  always @(posedge aclk) begin
    for (int i = 0; i < 2; i++) begin
      if (gen_tick[i] || div_r == 3'h3) begin
        async_rx_pin[i] <= rx_bits[i];
      end
    end
  end
endmodule : asxc_line_model

/* testbench/tb.sv */
`timescale 1ns/1ps
module tb;
  import asxc_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0;
  logic [ADDR_W-1:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic carrier_detect_pin0_n, clear_to_send_pin0_n, rx_reset0, tx_data_empty_flag0, irq;
  logic io_stop_mode = 1'b0, tx_data_empty_raw0 = 1'b0;
  logic [1:0] tx_serial = 2'b11, rx_head_new = 2'b00, rx_head_framing_err = 2'b00;
  logic [1:0] error_flag_reset_clr = 2'b00;
  logic [15:0] rx_head_data = 16'h0000;
  logic [1:0] async_rx_pin, async_clock_pin_i, async_tx_pin, async_clock_pin_o;
  logic [1:0] async_clock_pin_oe, bit_clk_en, rx_sync_data;
  logic carrier_on = 1'b1, cts_on = 1'b1, ext_on = 1'b0;
  logic [1:0] rx_bits = 2'b11;
  int mismatches = 0;
  int checks_done = 0;
  int cyc = 0;
  asxc_top asxc_top_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .carrier_detect_pin0_n, .clear_to_send_pin0_n,
    .io_stop_mode, .tx_data_empty_raw0, .tx_serial, .async_rx_pin, .async_clock_pin_i,
    .rx_head_new, .rx_head_data, .rx_head_framing_err, .error_flag_reset_clr,
    .async_tx_pin, .async_clock_pin_o, .async_clock_pin_oe, .bit_clk_en, .rx_sync_data,
    .rx_reset0, .tx_data_empty_flag0, .irq
  );
  asxc_line_model asxc_line_model_inst (
    .aclk, .carrier_on, .cts_on, .ext_on, .rx_bits, .gen_tick(async_clock_pin_o),
    .carrier_detect_pin0_n, .clear_to_send_pin0_n, .async_rx_pin, .async_clock_pin_i
  );
  always #50 aclk = ~aclk;
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask : wt
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(ASXC_OKAY), 32'(s_axi_bresp));
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rdata", e, s_axi_rdata);
    chk("rresp", 32'(er), 32'(s_axi_rresp));
  endtask : rd
  // Cycles between two pulses of clock pin 0 (sel 0) or bit clock 0 (sel 1)
  task automatic per(input int sel, input int e, input string nm);
    int p;
    p = 0;
    do @(posedge aclk); while (!(sel == 0 ? async_clock_pin_o[0] : bit_clk_en[0]));
    do begin
      @(posedge aclk);
      p++;
    end while (!(sel == 0 ? async_clock_pin_o[0] : bit_clk_en[0]));
    chk(nm, 32'(e), 32'(p));
  endtask : per
  task automatic head(input logic [7:0] d, input logic fe);
    @(posedge aclk);
    rx_head_new <= 2'b01;
    rx_head_data <= {8'h00, d};
    rx_head_framing_err <= {1'b0, fe};
    @(posedge aclk);
    rx_head_new <= 2'b00;
  endtask : head
  task automatic t_regs();
    rd(OFS_EXT0, 32'h0, ASXC_OKAY);
    rd(OFS_EXT1, 32'h0, ASXC_OKAY);
    wr(OFS_EXT0, 32'hff);
    rd(OFS_EXT0, 32'h7d, ASXC_OKAY);
    wr(OFS_EXT1, 32'hff);
    rd(OFS_EXT1, 32'h1d, ASXC_OKAY);
    rd(6'h3c, 32'h0, ASXC_SLVERR);
    wr(OFS_EXT0, 32'h0);
    wr(OFS_EXT1, 32'h0);
  endtask : t_regs
  task automatic t_carrier();
    wr(OFS_IMASK, 32'h1);
    wr(OFS_EXT0, 32'h04);
    head(8'h00, 1'b1);
    rd(OFS_EXT0, 32'h06, ASXC_OKAY);
    @(posedge aclk);
    carrier_on <= 1'b0;
    wt(3);
    chk("rx_reset0", 32'h1, 32'(rx_reset0));
    chk("irq", 32'h1, 32'(irq));
    rd(OFS_EXT0, 32'h04, ASXC_OKAY);
    rd(OFS_LINE, 32'h1, ASXC_OKAY);
    wr(OFS_EXT0, 32'h44);
    wt(3);
    chk("rx_reset0", 32'h0, 32'(rx_reset0));
    wr(OFS_ISTAT, 32'h7);
    wt(3);
    chk("irq", 32'h0, 32'(irq));
    carrier_on <= 1'b1;
    wt(3);
    carrier_on <= 1'b0;
    wt(3);
    chk("irq", 32'h1, 32'(irq));
    wr(OFS_ISTAT, 32'h7);
    carrier_on <= 1'b1;
    wr(OFS_EXT0, 32'h0);
  endtask : t_carrier
  task automatic t_break();
    head(8'h00, 1'b1);
    rd(OFS_EXT0, 32'h0, ASXC_OKAY);
    wr(OFS_EXT0, 32'h04);
    head(8'h01, 1'b1);
    head(8'h00, 1'b0);
    rd(OFS_EXT0, 32'h04, ASXC_OKAY);
    head(8'h00, 1'b1);
    rd(OFS_EXT0, 32'h06, ASXC_OKAY);
    error_flag_reset_clr <= 2'b01;
    @(posedge aclk);
    error_flag_reset_clr <= 2'b00;
    rd(OFS_EXT0, 32'h04, ASXC_OKAY);
    head(8'h00, 1'b1);
    io_stop_mode <= 1'b1;
    @(posedge aclk);
    io_stop_mode <= 1'b0;
    rd(OFS_EXT0, 32'h04, ASXC_OKAY);
    wr(OFS_EXT0, 32'h01);
    wt(3);
    chk("async_tx_pin", 32'h3, 32'(async_tx_pin));
    wr(OFS_EXT0, 32'h05);
    wr(OFS_EXT1, 32'h05);
    wt(3);
    chk("async_tx_pin", 32'h0, 32'(async_tx_pin));
    wr(OFS_EXT0, 32'h04);
    wr(OFS_EXT1, 32'h0);
    wt(3);
    chk("async_tx_pin", 32'h3, 32'(async_tx_pin));
    wr(OFS_ISTAT, 32'h7);
    wr(OFS_EXT0, 32'h0);
  endtask : t_break
  task automatic t_cts();
    tx_data_empty_raw0 <= 1'b1;
    cts_on <= 1'b0;
    wt(3);
    chk("tx_data_empty_flag0", 32'h0, 32'(tx_data_empty_flag0));
    wr(OFS_EXT0, 32'h20);
    wt(3);
    chk("tx_data_empty_flag0", 32'h1, 32'(tx_data_empty_flag0));
    cts_on <= 1'b1;
    wr(OFS_EXT0, 32'h0);
    wt(3);
    chk("tx_data_empty_flag0", 32'h1, 32'(tx_data_empty_flag0));
  endtask : t_cts
  task automatic t_baud();
    wr(OFS_EXT0, 32'h10);
    per(0, 10, "gen period");
    per(1, 10, "bit period");
    chk("async_clock_pin_oe", 32'h1, 32'(async_clock_pin_oe[0]));
    wr(OFS_CTLB0, 32'h21);
    per(0, 60, "gen period");
    wr(OFS_EXT0, 32'h0);
    wr(OFS_CTLB0, 32'h0);
    per(1, 160, "bit period");
    wr(OFS_CTLB0, 32'h08);
    per(1, 640, "bit period");
    rx_bits <= 2'b10;
    wt(30);
    chk("rx_sync_data", 32'h2, 32'(rx_sync_data));
    wr(OFS_EXT0, 32'h18);
    wr(OFS_TC0, 32'h1);
    per(0, 6, "gen period");
    ext_on <= 1'b1;
    wr(OFS_CTLB0, 32'h07);
    wt(3);
    chk("async_clock_pin_oe", 32'h0, 32'(async_clock_pin_oe[0]));
    per(1, 8, "bit period");
    ext_on <= 1'b0;
    wr(OFS_CTLB0, 32'h0);
    wr(OFS_EXT0, 32'h0);
  endtask : t_baud
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_carrier();
    t_break();
    t_cts();
    t_baud();
    stop_test();
  end
endmodule : tb
